// *** pmcs_top.sv ***
// Summary of operation
// - Sleep stops the processor clock until reset or an enabled interrupt.
// - In sleep, enabled peripheral clocks run and their interrupts wake the core.
// - Sleep and deep-sleep keep state, SRAM and registers, and hold pins static.
// - Deep-sleep stops processor clock, and main and peripheral clocks unless kept.
// - Deep-sleep puts the flash into standby.
// - Deep-sleep powers down analog blocks except those kept as wake sources.
// - Configured functions and oscillators keep running through deep-sleep.
// - Deep power-down powers off everything but the reset pin and those RTC domain functions kept in the deep-sleep keep bits.
// - Deep power-down ends only on reset pin assertion or RTC alarm.
// - Once the watchdog is enabled its configuration is frozen until reset.
// - Supply below a fixed level sets a sticky flag, pollable or interrupting.
// - Separate selectable brownout levels raise reset and interrupt.
// - PLL reference selects internal 12 MHz, external clock pin or RTC clock.
// - Software enables and disables the PLL.
// - High-speed oscillator output runs at selected 96 MHz or 48 MHz.
// - The main clock drives processor and system bus and other consumers.
// - After any reset the internal 12 MHz oscillator is the main clock.
// - Deep power-down keeps no state; waking from it acts as full reset.
// - All functional pins are high impedance in deep power-down.
module pmcs_top
    import pmcs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        wake_irq,
    input  wire logic [11:0] ds_wake_evt,
    input  wire logic        reset_pin_b,
    input  wire logic        rtc_alarm,
    input  wire logic [7:0]  vdd_level,
    output pmcs_clk_t        clk_ctrl,
    output pmcs_pwr_t        pwr_ctrl,
    output logic [15:0]      wdt_cfg,
    output logic             bod_irq,
    output logic             bod_reset_req
);

    // ********************************************************
    // Bus slave
    // ********************************************************
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;
    logic        wr_fire;
    logic        rd_take;

    logic [31:0] clk_sel_q;
    logic [31:0] pclk_en_q;
    logic [31:0] ds_keep_q;
    logic [31:0] wdt_cfg_q;
    logic [31:0] bod_cfg_q;
    logic        rtc_en_q;
    logic        bod_flag_q;
    logic        wipe_q;
    logic        reg_clr;
    logic        mode_go;
    logic [1:0]  mode_val;
    logic        busy;

    pmcs_state_t state_q;
    pmcs_state_t state_d;
    logic [3:0]  wcnt_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return res;
    endfunction

    // One wait cycle per access; the request completes when ack_q is high.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_fire         = avs_write & ack_q;
    assign rd_take         = avs_read & ~ack_q;
    assign avs_readdata    = rdata_q;
    assign reg_clr         = ~rst_b | wipe_q;
    assign mode_go         = wr_fire & (avs_address == ADDR_MODE) & avs_byteenable[0];
    assign mode_val        = avs_writedata[1:0];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            ADDR_MODE:    rd_mux = 32'h0000_0000;
            ADDR_CLK_SEL: rd_mux = clk_sel_q;
            ADDR_PCLK_EN: rd_mux = pclk_en_q;
            ADDR_DS_KEEP: rd_mux = ds_keep_q;
            ADDR_WDT_CFG: rd_mux = wdt_cfg_q;
            ADDR_BOD_CFG: rd_mux = bod_cfg_q;
            ADDR_RTC_OSC: rd_mux = {31'h0000_0000, rtc_en_q};
            ADDR_STATUS: begin
                rd_mux[ST_BOD_BIT]              = bod_flag_q;
                rd_mux[ST_LOCK_BIT]             = wdt_cfg_q[WDT_EN_BIT];
                rd_mux[ST_BUSY_BIT]             = busy;
                rd_mux[ST_STATE_LSB +: 7]       = state_q;
            end
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_take) begin
            rdata_q <= rd_mux;
        end
    end

    // ********************************************************
    // Configuration registers
    // ********************************************************
    always_ff @(posedge clk) begin
        if (reg_clr) begin
            clk_sel_q <= CLK_SEL_RST;
            pclk_en_q <= PCLK_EN_RST;
            ds_keep_q <= DS_KEEP_RST;
            bod_cfg_q <= BOD_CFG_RST;
            rtc_en_q  <= 1'b0;
        end else if (wr_fire) begin
            case (avs_address)
                ADDR_CLK_SEL: clk_sel_q <= merge(clk_sel_q, avs_writedata, avs_byteenable);
                ADDR_PCLK_EN: pclk_en_q <= merge(pclk_en_q, avs_writedata, avs_byteenable);
                ADDR_DS_KEEP: ds_keep_q <= merge(ds_keep_q, avs_writedata, avs_byteenable);
                ADDR_BOD_CFG: bod_cfg_q <= merge(bod_cfg_q, avs_writedata, avs_byteenable);
                ADDR_RTC_OSC: begin
                    if (avs_byteenable[0]) begin
                        rtc_en_q <= avs_writedata[RTC_EN_BIT];
                    end
                end
                default: ;
            endcase
        end
    end

    // Once the enable bit is set, every later write is dropped.
    always_ff @(posedge clk) begin
        if (reg_clr) begin
            wdt_cfg_q <= WDT_CFG_RST;
        end else if (wr_fire && avs_address == ADDR_WDT_CFG && !wdt_cfg_q[WDT_EN_BIT]) begin
            wdt_cfg_q <= merge(wdt_cfg_q, avs_writedata, avs_byteenable);
        end
    end

    assign wdt_cfg = wdt_cfg_q[15:0];

    // ********************************************************
    // Brownout
    // ********************************************************
    logic bod_run;
    logic bod_below_fix;
    logic bod_below_int;
    logic bod_below_rst;
    logic bod_clr;

    assign bod_run       = pwr_ctrl.func_run[KEEP_BOD_BIT];
    assign bod_below_fix = bod_run & (vdd_level < BOD_FLAG_LVL);
    assign bod_below_int = bod_run & (vdd_level < BOD_LEVELS[bod_cfg_q[BOD_ILVL_LSB +: 2]]);
    assign bod_below_rst = bod_run & (vdd_level < BOD_LEVELS[bod_cfg_q[BOD_RLVL_LSB +: 2]]);
    assign bod_clr       = wr_fire & (avs_address == ADDR_STATUS) & avs_byteenable[0]
                         & avs_writedata[ST_BOD_BIT];

    // A new brownout in the clearing cycle keeps the flag set.
    always_ff @(posedge clk) begin
        if (reg_clr) begin
            bod_flag_q <= 1'b0;
        end else if (bod_below_fix) begin
            bod_flag_q <= 1'b1;
        end else if (bod_clr) begin
            bod_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reg_clr) begin
            bod_irq       <= 1'b0;
            bod_reset_req <= 1'b0;
        end else begin
            bod_irq       <= bod_cfg_q[BOD_IEN_BIT] & (bod_flag_q | bod_below_int);
            bod_reset_req <= bod_cfg_q[BOD_REN_BIT] & bod_below_rst;
        end
    end

    // ********************************************************
    // Glitch-free clock multiplexers
    // ********************************************************
    // Index 0 is the main clock mux, index 1 the PLL reference mux.  The output
    // gate closes, the select moves only while closed, and the gate reopens a
    // gap later, so no runt pulse reaches the clock tree.
    logic [1:0][2:0] mux_req;
    logic [1:0][2:0] mux_sel_q;
    logic [1:0]      mux_gate_q;
    logic [1:0][3:0] mux_cnt_q;

    assign mux_req[0] = clk_sel_q[CLK_MAIN_LSB +: 3];
    assign mux_req[1] = {1'b0, clk_sel_q[CLK_REF_LSB +: 2]};
    assign busy       = ~&mux_gate_q | (mux_sel_q != mux_req);

    for (genvar m = 0; m < 2; m++) begin : g_mux
        always_ff @(posedge clk) begin
            if (reg_clr) begin
                mux_sel_q[m]  <= (m == 0) ? MAIN_OSC_LOW : REF_OSC_LOW;
                mux_gate_q[m] <= 1'b1;
                mux_cnt_q[m]  <= 4'h0;
            end else if (mux_gate_q[m]) begin
                if (mux_sel_q[m] != mux_req[m]) begin
                    mux_gate_q[m] <= 1'b0;
                    mux_cnt_q[m]  <= CLK_GAP_CYC;
                end
            end else if (mux_cnt_q[m] != 4'h0) begin
                mux_cnt_q[m] <= mux_cnt_q[m] - 4'h1;
            end else if (mux_sel_q[m] != mux_req[m]) begin
                mux_sel_q[m] <= mux_req[m];
                mux_cnt_q[m] <= CLK_GAP_CYC;
            end else begin
                mux_gate_q[m] <= 1'b1;
            end
        end
    end

    // ********************************************************
    // Power mode sequencer
    // ********************************************************
    logic ds_wake;
    logic dpd_wake;

    assign ds_wake  = wake_irq | (|(ds_wake_evt & ds_keep_q[NUM_FUNC-1:0])) | bod_irq;
    assign dpd_wake = ~reset_pin_b | rtc_alarm;

    always_comb begin
        state_d = state_q;
        case (state_q)
            PM_ACTIVE: begin
                if (mode_go) begin
                    case (mode_val)
                        MODE_SLEEP:  state_d = PM_SLEEP;
                        MODE_DSLEEP: state_d = PM_DS_ENTER;
                        MODE_DPD:    state_d = PM_DPD;
                        default:     state_d = PM_ACTIVE;
                    endcase
                end
            end
            PM_SLEEP:    state_d = wake_irq ? PM_ACTIVE : PM_SLEEP;
            PM_DS_ENTER: state_d = PM_DSLEEP;
            PM_DSLEEP:   state_d = ds_wake ? PM_DS_FLASH : PM_DSLEEP;
            PM_DS_FLASH: state_d = (wcnt_q == 4'h0) ? PM_DS_CLK : PM_DS_FLASH;
            PM_DS_CLK:   state_d = PM_ACTIVE;
            PM_DPD:      state_d = dpd_wake ? PM_ACTIVE : PM_DPD;
            default:     state_d = PM_ACTIVE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= PM_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wcnt_q <= 4'h0;
        end else if (state_q == PM_DSLEEP) begin
            wcnt_q <= FLASH_WAKE_CYC - 4'h1;
        end else if (wcnt_q != 4'h0) begin
            wcnt_q <= wcnt_q - 4'h1;
        end
    end

    // Leaving deep power-down clears all state, as a chip reset would.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wipe_q <= 1'b0;
        end else begin
            wipe_q <= (state_q == PM_DPD) & dpd_wake;
        end
    end

    // ********************************************************
    // Clock and power outputs
    // ********************************************************
    pmcs_clk_t clk_d;
    pmcs_pwr_t pwr_d;
    logic      in_ds;
    logic      run_mode;

    assign in_ds    = (state_q == PM_DS_ENTER) | (state_q == PM_DSLEEP) | (state_q == PM_DS_FLASH);
    assign run_mode = (state_q == PM_ACTIVE) | (state_q == PM_SLEEP);

    always_comb begin
        clk_d              = '0;
        clk_d.main_sel     = mux_sel_q[0];
        clk_d.main_gate    = mux_gate_q[0] & (mux_sel_q[0] != MAIN_NONE);
        clk_d.pll_ref_sel  = mux_sel_q[1];
        clk_d.pll_ref_gate = mux_gate_q[1] & (mux_sel_q[1] != REF_NONE);
        clk_d.pll_en       = clk_sel_q[CLK_PLL_BIT] & run_mode;
        clk_d.osc_high_96  = ~clk_sel_q[CLK_HF48_BIT];
        clk_d.rtc_slow_en  = rtc_en_q;
        clk_d.main_en      = run_mode | (state_q == PM_DS_CLK)
                           | (in_ds & ds_keep_q[KEEP_CLK_BIT]);
        clk_d.ahb_en       = clk_d.main_en;
        clk_d.cpu_en       = (state_q == PM_ACTIVE);
        clk_d.periph_en    = clk_d.main_en ? pclk_en_q[15:0] : 16'h0000;
    end

    always_comb begin
        pwr_d               = '0;
        pwr_d.core_pwr_on   = (state_q != PM_DPD);
        pwr_d.sram_retain   = (state_q != PM_DPD);
        pwr_d.pin_hold      = ~run_mode | (state_q == PM_SLEEP);
        pwr_d.pin_hiz       = (state_q == PM_DPD);
        pwr_d.flash_standby = in_ds & (state_q != PM_DS_FLASH);
        pwr_d.chip_reset_req = wipe_q;
        if (run_mode) begin
            pwr_d.func_run = {NUM_FUNC{1'b1}};
        end else if (state_q == PM_DPD) begin
            pwr_d.func_run = RTC_DOMAIN & ds_keep_q[NUM_FUNC-1:0];
        end else begin
            pwr_d.func_run = ds_keep_q[NUM_FUNC-1:0];
        end
        pwr_d.analog_pd = ~pwr_d.func_run[ANALOG_LSB +: NUM_ANALOG];
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clk_ctrl          <= '0;
            clk_ctrl.cpu_en   <= 1'b1;
            clk_ctrl.ahb_en   <= 1'b1;
            clk_ctrl.main_en  <= 1'b1;
            clk_ctrl.main_sel <= MAIN_OSC_LOW;
            clk_ctrl.main_gate <= 1'b1;
        end else begin
            clk_ctrl <= clk_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pwr_ctrl             <= '0;
            pwr_ctrl.core_pwr_on <= 1'b1;
            pwr_ctrl.sram_retain <= 1'b1;
            pwr_ctrl.func_run    <= {NUM_FUNC{1'b1}};
        end else begin
            pwr_ctrl <= pwr_d;
        end
    end

endmodule

// *** pmcs_pkg.sv ***
package pmcs_pkg;

    // ********************************************************
    // Register map and field layout
    // ********************************************************
    localparam logic [7:0]  ADDR_MODE    = 8'h00;
    localparam logic [7:0]  ADDR_CLK_SEL = 8'h04;
    localparam logic [7:0]  ADDR_PCLK_EN = 8'h08;
    localparam logic [7:0]  ADDR_DS_KEEP = 8'h0c;
    localparam logic [7:0]  ADDR_WDT_CFG = 8'h10;
    localparam logic [7:0]  ADDR_BOD_CFG = 8'h14;
    localparam logic [7:0]  ADDR_STATUS  = 8'h18;
    localparam logic [7:0]  ADDR_RTC_OSC = 8'h1c;

    localparam logic [1:0]  MODE_SLEEP   = 2'h1;
    localparam logic [1:0]  MODE_DSLEEP  = 2'h2;
    localparam logic [1:0]  MODE_DPD     = 2'h3;

    localparam int          CLK_MAIN_LSB = 0;
    localparam int          CLK_REF_LSB  = 4;
    localparam int          CLK_HF48_BIT = 8;
    localparam int          CLK_PLL_BIT  = 9;
    localparam logic [2:0]  MAIN_OSC_LOW = 3'h0;
    localparam logic [2:0]  MAIN_NONE    = 3'h4;
    localparam logic [2:0]  REF_OSC_LOW  = 3'h0;
    localparam logic [2:0]  REF_EXT_PIN  = 3'h1;
    localparam logic [2:0]  REF_RTC_SLOW = 3'h2;
    localparam logic [2:0]  REF_NONE     = 3'h3;
    localparam logic [31:0] CLK_SEL_RST  = 32'h0000_0000;

    // Deep-sleep keep bits: 0 pin int, 1 group int, 2 serial, 3 usb, 4 mic,
    // 5 watchdog, 6 rtc, 7 micro-tick, 8 brownout, 9 internal osc,
    // 10 rtc osc, 11 watchdog osc.  Bit 12 keeps main and peripheral clocks.
    localparam int          NUM_FUNC     = 12;
    localparam int          KEEP_BOD_BIT = 8;
    localparam int          ANALOG_LSB   = 8;
    localparam int          NUM_ANALOG   = 4;
    localparam int          KEEP_CLK_BIT = 12;
    localparam logic [11:0] RTC_DOMAIN   = 12'h440;
    localparam logic [31:0] DS_KEEP_RST  = 32'h0000_0000;
    localparam logic [31:0] PCLK_EN_RST  = 32'h0000_0000;

    localparam int          WDT_EN_BIT   = 0;
    localparam logic [31:0] WDT_CFG_RST  = 32'h0000_0000;

    localparam int          BOD_RLVL_LSB = 0;
    localparam int          BOD_ILVL_LSB = 2;
    localparam int          BOD_REN_BIT  = 4;
    localparam int          BOD_IEN_BIT  = 5;
    localparam logic [31:0] BOD_CFG_RST  = 32'h0000_0000;
    localparam logic [7:0]  BOD_FLAG_LVL = 8'h80;
    localparam logic [3:0][7:0] BOD_LEVELS = {8'h90, 8'h88, 8'h78, 8'h70};

    localparam int          ST_BOD_BIT   = 0;
    localparam int          ST_LOCK_BIT  = 1;
    localparam int          ST_BUSY_BIT  = 2;
    localparam int          ST_STATE_LSB = 8;
    localparam int          RTC_EN_BIT   = 0;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int          CLK_MHZ       = 40;
    localparam int          FLASH_WAKE_NS = 100;
    localparam int          CLK_GAP_NS    = 50;
    localparam logic [3:0]  FLASH_WAKE_CYC = 4'((FLASH_WAKE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0]  CLK_GAP_CYC    = 4'((CLK_GAP_NS * CLK_MHZ + 999) / 1000);

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [6:0] {
        PM_ACTIVE   = 7'b000_0001,
        PM_SLEEP    = 7'b000_0010,
        PM_DS_ENTER = 7'b000_0100,
        PM_DSLEEP   = 7'b000_1000,
        PM_DS_FLASH = 7'b001_0000,
        PM_DS_CLK   = 7'b010_0000,
        PM_DPD      = 7'b100_0000
    } pmcs_state_t;

    typedef struct packed {
        logic        cpu_en;
        logic        ahb_en;
        logic        main_en;
        logic [15:0] periph_en;
        logic [2:0]  main_sel;
        logic        main_gate;
        logic [2:0]  pll_ref_sel;
        logic        pll_ref_gate;
        logic        pll_en;
        logic        osc_high_96;
        logic        rtc_slow_en;
    } pmcs_clk_t;

    typedef struct packed {
        logic        pin_hold;
        logic        pin_hiz;
        logic        flash_standby;
        logic        core_pwr_on;
        logic        sram_retain;
        logic        chip_reset_req;
        logic [11:0] func_run;
        logic [3:0]  analog_pd;
    } pmcs_pwr_t;

endpackage

// *** pmcs_properties.sv ***
module pmcs_properties
    import pmcs_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        wake_irq,
    input wire logic        reset_pin_b,
    input wire logic        rtc_alarm,
    input wire pmcs_clk_t   clk_ctrl,
    input wire pmcs_pwr_t   pwr_ctrl,
    input wire logic [15:0] wdt_cfg
);
    // ********************************************************
    // Checks at the ports
    // ********************************************************
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_sleep_wake_cpu: assert property (
        !clk_ctrl.cpu_en && clk_ctrl.main_en && !pwr_ctrl.flash_standby && !pwr_ctrl.pin_hiz
        && wake_irq |-> ##2 clk_ctrl.cpu_en) else $error("cpu clock not back after wake");
    a_standby_holds: assert property (
        pwr_ctrl.flash_standby |-> !clk_ctrl.cpu_en && pwr_ctrl.pin_hold && pwr_ctrl.sram_retain)
        else $error("standby without held state");
    a_flash_before_cpu: assert property (
        $rose(clk_ctrl.cpu_en) && !$past(pwr_ctrl.pin_hiz) |-> !pwr_ctrl.flash_standby
        && clk_ctrl.main_en) else $error("cpu clock before flash and main clock");
    a_dpd_power_off: assert property (
        pwr_ctrl.pin_hiz |-> !pwr_ctrl.core_pwr_on && !pwr_ctrl.sram_retain && !clk_ctrl.cpu_en)
        else $error("power left on in deep power-down");
    a_dpd_stays: assert property (
        (reset_pin_b && !rtc_alarm)[*3] ##0 pwr_ctrl.pin_hiz |=> pwr_ctrl.pin_hiz)
        else $error("deep power-down left without a wake source");
    a_wdt_frozen: assert property (
        wdt_cfg[WDT_EN_BIT] && !pwr_ctrl.pin_hiz |=> $stable(wdt_cfg))
        else $error("watchdog setting changed while locked");
    a_mux_gap_clean: assert property (
        $changed(clk_ctrl.main_sel) && !$past(pwr_ctrl.chip_reset_req)
        |-> !clk_ctrl.main_gate && !$past(clk_ctrl.main_gate))
        else $error("main select changed with gate open");
    a_reset_osc_low: assert property (
        $rose(rst_b) |-> clk_ctrl.main_sel == MAIN_OSC_LOW && clk_ctrl.main_gate)
        else $error("main clock not internal osc after reset");
    a_ref_legal: assert property (
        clk_ctrl.pll_ref_sel <= REF_NONE) else $error("illegal pll reference");
endmodule

bind pmcs_top pmcs_properties u_props (.clk(clk), .rst_b(rst_b), .wake_irq(wake_irq),
    .reset_pin_b(reset_pin_b), .rtc_alarm(rtc_alarm), .clk_ctrl(clk_ctrl),
    .pwr_ctrl(pwr_ctrl), .wdt_cfg(wdt_cfg));

// *** pmcs_wake_model.sv ***
module pmcs_wake_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       cpu_en,
    input  wire logic [1:0] go,
    input  wire logic [3:0] dly,
    output logic            wake_irq,
    output logic            rtc_alarm
);
    logic [1:0] pend_q;
    logic [1:0] src_q;
    logic [3:0] cnt_q;

    // A source holds its level until the core runs again, as a real one does.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pend_q <= 2'h0;
            src_q  <= 2'h0;
            cnt_q  <= 4'h0;
        end else if (go != 2'h0) begin
            pend_q <= go;
            cnt_q  <= dly;
        end else if (pend_q != 2'h0 && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (pend_q != 2'h0) begin
            src_q  <= pend_q;
            pend_q <= 2'h0;
        end else if (cpu_en) begin
            src_q <= 2'h0;
        end
    end
    assign wake_irq  = src_q[0];
    assign rtc_alarm = src_q[1];
endmodule

// *** tb_power_mode_clock_sequencer.sv ***
module tb_power_mode_clock_sequencer
    import pmcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] r;} pmcs_row_t;
    logic        clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0]  avs_address = 8'h00, vdd_level = 8'hc0;
    logic        reset_pin_b = 1'b1;
    logic [11:0] ds_wake_evt = 12'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [1:0]  go = 2'h0;
    logic [3:0]  dly = 4'h2;
    logic        avs_waitrequest, wake_irq, rtc_alarm, bod_irq, bod_reset_req;
    logic [15:0] wdt_cfg;
    pmcs_clk_t   clk_ctrl;
    pmcs_pwr_t   pwr_ctrl;
    int          fails = 0, n_compared = 0, i;
    pmcs_row_t   rows [7] = '{'{ADDR_RTC_OSC, 32'h1, 32'h1}, '{ADDR_CLK_SEL, 32'h221, 32'h221},
        '{ADDR_PCLK_EN, 32'h1234, 32'h1234}, '{ADDR_DS_KEEP, 32'h100, 32'h100},
        '{ADDR_BOD_CFG, 32'h38, 32'h38}, '{8'h20, 32'hffff, 32'h0}, '{ADDR_MODE, 32'h0, 32'h0}};

    always #12.5 clk = ~clk;
    pmcs_top dut_u (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wake_irq(wake_irq),
        .ds_wake_evt(ds_wake_evt), .reset_pin_b(reset_pin_b), .rtc_alarm(rtc_alarm),
        .vdd_level(vdd_level), .clk_ctrl(clk_ctrl), .pwr_ctrl(pwr_ctrl), .wdt_cfg(wdt_cfg),
        .bod_irq(bod_irq), .bod_reset_req(bod_reset_req));
    pmcs_wake_model u_wake (.clk(clk), .rst_b(rst_b), .cpu_en(clk_ctrl.cpu_en), .go(go),
        .dly(dly), .wake_irq(wake_irq), .rtc_alarm(rtc_alarm));

    // ********************************************************
    // Helpers
    // ********************************************************
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (avs_waitrequest !== 1'b0) begin
            fails++;
            summarize();
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wake(input logic [1:0] s, input logic [3:0] d);
        go <= s;
        dly <= d;
        @(posedge clk);
        go <= 2'h0;
    endtask
    task automatic wait_cpu();
        for (i = 0; i < 100 && clk_ctrl.cpu_en !== 1'b1; i++) @(posedge clk);
        if (i == 100) begin
            fails++;
            summarize();
        end
    endtask

    // ********************************************************
    // Sequence
    // ********************************************************
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk(32'(clk_ctrl.main_sel), 32'(MAIN_OSC_LOW));
        foreach (rows[j]) begin
            bus(1'b1, rows[j].a, rows[j].d);
            bus(1'b0, rows[j].a, 32'h0);
            chk(rd, rows[j].r);
        end
        repeat (8) @(posedge clk);
        chk(32'({clk_ctrl.pll_en, clk_ctrl.pll_ref_sel, clk_ctrl.main_sel}), 32'h51);
        chk(32'({clk_ctrl.osc_high_96, clk_ctrl.rtc_slow_en, clk_ctrl.main_gate}), 32'h7);
        bus(1'b1, ADDR_MODE, 32'(MODE_SLEEP));
        repeat (3) @(posedge clk);
        chk(32'({clk_ctrl.cpu_en, clk_ctrl.ahb_en, pwr_ctrl.pin_hold}), 32'h3);
        chk(32'(clk_ctrl.periph_en), 32'h1234);
        wake(2'h1, 4'h3);
        wait_cpu();
        bus(1'b1, ADDR_MODE, 32'(MODE_DSLEEP));
        repeat (4) @(posedge clk);
        chk(32'({pwr_ctrl.flash_standby, clk_ctrl.main_en, clk_ctrl.periph_en}), 32'h20000);
        chk(32'({pwr_ctrl.func_run, pwr_ctrl.analog_pd}), 32'h100e);
        ds_wake_evt <= 12'h0ff;
        repeat (3) @(posedge clk);
        chk(32'(pwr_ctrl.flash_standby), 32'h1);
        ds_wake_evt <= 12'h000;
        wake(2'h1, 4'h9);
        wait_cpu();
        chk(32'({pwr_ctrl.flash_standby, clk_ctrl.main_en}), 32'h1);
        vdd_level <= 8'h7c;
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        chk(32'({bod_irq, bod_reset_req}), 32'h2);
        vdd_level <= 8'h6c;
        repeat (4) @(posedge clk);
        chk(32'(bod_reset_req), 32'h1);
        vdd_level <= 8'hc0;
        bus(1'b1, ADDR_STATUS, 32'h1);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h0);
        bus(1'b1, ADDR_CLK_SEL, 32'h30);
        bus(1'b1, ADDR_MODE, 32'(MODE_DPD));
        repeat (4) @(posedge clk);
        chk(32'({pwr_ctrl.pin_hiz, pwr_ctrl.core_pwr_on, pwr_ctrl.sram_retain}), 32'h4);
        wake(2'h1, 4'h2);
        repeat (8) @(posedge clk);
        chk(32'(pwr_ctrl.pin_hiz), 32'h1);
        chk(32'({clk_ctrl.pll_ref_sel, clk_ctrl.pll_ref_gate}), 32'h6);
        wake(2'h2, 4'h2);
        wait_cpu();
        chk(32'(pwr_ctrl.chip_reset_req), 32'h1);
        repeat (3) @(posedge clk);
        bus(1'b0, ADDR_PCLK_EN, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, ADDR_WDT_CFG, 32'ha5);
        bus(1'b1, ADDR_WDT_CFG, 32'h1234);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(32'({wdt_cfg, rd[ST_LOCK_BIT]}), 32'h14b);
        bus(1'b1, ADDR_MODE, 32'(MODE_DPD));
        repeat (3) @(posedge clk);
        reset_pin_b <= 1'b0;
        wait_cpu();
        reset_pin_b <= 1'b1;
        chk(32'(wdt_cfg), 32'h0);
        summarize();
    end
endmodule
